// ===== rtl/rsa_pkg.sv
// Package for the receive sequence with automatic acknowledgement: map, timing, types
package rsa_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_TIMING = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_RXINFO = 12'h00C;

	// Sequence codes written to sequence_select
	localparam logic [2:0] SEL_IDLE  = 3'h0;
	localparam logic [2:0] SEL_RX    = 3'h1;
	localparam logic [2:0] SEL_TX    = 3'h2;
	localparam logic [2:0] SEL_CCA   = 3'h3;
	localparam logic [2:0] SEL_TR    = 3'h4;
	localparam logic [2:0] SEL_CCCA  = 3'h5;

	// Timebase: the sequencer steps in 2 us ticks
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_US       = 2;
	localparam int TICK_CYCLES   = STEP_US * 1000 / CLK_PERIOD_NS;

	// Times in microseconds, except ACK_EXTRA_SYMS in symbols
	localparam int RX_WARMUP_US    = 144;
	localparam int SFD_OFFSET_US   = 160;
	localparam int SLOT_US         = 320;
	localparam int SLOT_LAST_US    = 319;
	localparam int TURNAROUND_US   = 192;
	localparam int SYMBOL_US       = 16;
	localparam int ACK_EXTRA_SYMS  = 0;
	localparam int RX_WARMDOWN_US  = 10;
	localparam int TX_WARMDOWN_US  = 10;
	localparam int ABORT_WDOWN_US  = 10;

	// Frame handling
	localparam logic [6:0] MAX_PAYLOAD   = 7'h7F;
	localparam int         FCF_ACKREQ    = 5;
	localparam int         FCF_FV_LO     = 4;
	localparam logic [2:0] FTYPE_ACK     = 3'h2;
	localparam logic [2:0] IDX_FCF_LO    = 3'h1;
	localparam logic [2:0] IDX_FCF_HI    = 3'h2;
	localparam logic [2:0] IDX_SEQ       = 3'h3;
	localparam logic [2:0] IDX_DONE      = 3'h4;

	// Control register, LSB first: select[2:0], then one bit per option
	typedef struct packed {
		logic       lock_loss_abort_disable;
		logic       cca_before_tx;
		logic       ack_pending_default;
		logic       source_match_enable;
		logic       slotted;
		logic       accept_all;
		logic       auto_ack_enable;
		logic       bracket_timeout_enable;
		logic       timer_trigger_enable;
		logic [2:0] sequence_select;
	} rsa_ctrl_t;

	typedef struct packed {
		logic signed [5:0] ack_time_trim;
		logic [7:0]        tx_warmup_duration;
	} rsa_timing_t;

	typedef struct packed {
		logic [15:0] fcf;
		logic [7:0]  seq;
	} rsa_ack_t;

	localparam rsa_ctrl_t   CTRL_RST   = 12'h000;
	localparam rsa_timing_t TIMING_RST = 14'h0000;

	typedef enum logic [3:0] {
		ST_IDLE      = 4'h0,
		ST_WAIT_TRIG = 4'h1,
		ST_RX_WARMUP = 4'h3,
		ST_PREAMBLE  = 4'h2,
		ST_SFD       = 4'h6,
		ST_RX_DATA   = 4'h7,
		ST_RX_WDOWN  = 4'h5,
		ST_ACK_WAIT  = 4'h4,
		ST_TX_WARMUP = 4'hC,
		ST_TX_FRAME  = 4'hD,
		ST_TX_WDOWN  = 4'hF,
		ST_ABORT     = 4'hE,
		ST_CCA       = 4'hA,
		ST_CCA_GAP   = 4'hB
	} rsa_state_t;

endpackage

// ===== rtl/rsa_rx_seq.sv
// Receive sequence manager with hardware acknowledgement and AHB-Lite registers
// Summary of operation
// R1: With trigger enable set, start waits for start compare match; else starts on write.
// R2: Receive start warms the receiver for 144 us before preamble search.
// R3: Bracket timer match with timeout enabled warms down and returns idle.
// R4: Preamble search then delimiter search; delimiter loads slot timer 160+warmup+2*trim.
// R5: Slot timer steps every 2 us and wraps 319 to 0.
// R6: From length octet on, each octet goes to packet buffer, address plus one.
// R7: Octets after length equal the length, capped at 127.
// R8: Two frame control octets give AckRequest and FrameVersion; sequence number held.
// R9: Filter or CRC failure returns to preamble search after the last octet.
// R10: Good frame raises rx done, then warms down before ack decision.
// R11: Ack only with auto ack on, accept-all off, AckRequest set.
// R12: Non-slotted ack timer loads 192-warmup-2*trim+16*extra symbols (extra is zero).
// R13: Ack time trim is signed, spanning -64 to +62 us.
// R14: Slotted: under 192 us left in slot means wait one extra rollover.
// R15: Tx warmup starts on ack timer expiry or qualified slot rollover.
// R16: Ack frame built wholly by hardware, packet buffer untouched.
// R17: Ack frame control: type ack, frame pending per R18, other bits zero, FrameVersion copied.
// R18: Frame pending from source match when enabled, else from pending default.
// R19: Ack carries the sequence number just received.
// R20: After ack: tx done, tx warmdown, sequence done, idle.
// R21: Transmit may run one or two clear channel checks; busy ends without sending.
// R22: Sequence codes 0 idle, 1 rx, 2 tx, 3 cca, 4 tx-rx, 5 continuous cca; codes 3 to 5 start nothing.
// R23: Writing idle aborts with warmdown and sequence done; other mid-sequence select codes ignored.
// R24: PLL unlock past early warmup aborts unless abort disable set; unlock during any warmup or warmdown is ignored.
// R25: Buffer address returns to zero at each delimiter detection.
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
module rsa_rx_seq
	import rsa_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        start_compare_timer,
	input  wire logic        bracket_timer,
	input  wire logic        pll_unlock,
	input  wire logic        preamble_det,
	input  wire logic        sfd_det,
	input  wire logic        rx_octet_valid,
	input  wire logic [7:0]  rx_octet,
	input  wire logic        filter_fail,
	input  wire logic        crc_ok,
	input  wire logic        src_match_pending,
	input  wire logic        cca_done,
	input  wire logic        cca_busy,
	input  wire logic        tx_frame_done,
	output logic             rx_enable,
	output logic             tx_enable,
	output logic             cca_start,
	output logic             tx_frame_start,
	output logic             tx_ack_mode,
	output rsa_ack_t         ack_frame,
	output logic             pbuf_we,
	output logic      [6:0]  pbuf_addr,
	output logic      [7:0]  pbuf_wdata,
	output logic             rx_done_irq,
	output logic             tx_done_irq,
	output logic             sequence_done_irq
);

	rsa_state_t         state_r;
	rsa_ctrl_t          ctrl_r;
	rsa_timing_t        timing_r;
	logic               seq_wr_r;
	logic               wr_pend_r;
	logic [3:0]         wr_dec_r;
	logic [7:0]         tick_cnt_r;
	logic               tick;
	logic signed [11:0] wait_us_r;
	logic               wait_done;
	logic [8:0]         slot_cnt_r;
	logic               slot_run_r;
	logic               slot_roll_r;
	logic               extra_slot_r;
	logic               second_cca_r;
	logic               unlock_s1_r;
	logic               unlock_s2_r;
	logic               abort_req;
	logic [6:0]         ptr_r;
	logic [6:0]         left_r;
	logic [2:0]         idx_r;
	logic               ack_req_r;
	logic [1:0]         frame_ver_r;
	logic [7:0]         rx_seq_r;
	logic               frame_end_r;
	logic               frame_bad_r;
	logic               last_octet;
	logic signed [11:0] tw_us;
	logic signed [11:0] trim2_us;
	logic signed [11:0] slot_pre;
	logic signed [11:0] ack_pre;
	logic               ack_needed;
	logic               launch_rx;
	logic [3:0]         rd_dec;

	// One-hot decode; unmapped addresses give zero
	function automatic logic [3:0] addr_dec(input logic [31:0] a);
		logic [3:0] d;
		d = 4'h0;
		if (a[31:12] == 20'h00000) begin
			d[0] = (a[11:0] == ADDR_CTRL);
			d[1] = (a[11:0] == ADDR_TIMING);
			d[2] = (a[11:0] == ADDR_STATUS);
			d[3] = (a[11:0] == ADDR_RXINFO);
		end
		return d;
	endfunction

	assign rd_dec = addr_dec(haddr);

	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_pend_r <= 1'b0;
			wr_dec_r  <= 4'h0;
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend_r <= hsel && htrans[1] && hready && hwrite;
			wr_dec_r  <= rd_dec;
			if (hsel && htrans[1] && hready && !hwrite) begin
				hrdata <= 32'h00000000;
				if (rd_dec[0])
					hrdata <= {20'h00000, ctrl_r};
				if (rd_dec[1])
					hrdata <= {18'h00000, timing_r};
				if (rd_dec[2])
					hrdata <= {18'h00000, extra_slot_r, slot_cnt_r, state_r};
				if (rd_dec[3])
					hrdata <= {13'h0000, frame_bad_r, ptr_r, ack_req_r, frame_ver_r, rx_seq_r};
			end
		end
	end

	// Register writes; select guarded mid-sequence
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r   <= CTRL_RST;
			timing_r <= TIMING_RST;
			seq_wr_r <= 1'b0;
		end else begin
			seq_wr_r <= 1'b0;
			if (wr_pend_r && wr_dec_r[0]) begin
				ctrl_r[11:3] <= hwdata[11:3];
				if (state_r == ST_IDLE || hwdata[2:0] == SEL_IDLE) begin // [R23]
					ctrl_r.sequence_select <= hwdata[2:0]; // [R22]
					seq_wr_r               <= 1'b1;
				end
			end
			if (wr_pend_r && wr_dec_r[1])
				timing_r <= hwdata[13:0];
		end
	end

	// 2 us timebase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tick_cnt_r <= 8'h00;
		else if (tick)
			tick_cnt_r <= 8'h00;
		else
			tick_cnt_r <= tick_cnt_r + 8'h01;
	end
	assign tick = (tick_cnt_r == 8'(TICK_CYCLES - 1));

	// Unlock is asynchronous: synchronise first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unlock_s1_r <= 1'b0;
			unlock_s2_r <= 1'b0;
		end else begin
			unlock_s1_r <= pll_unlock;
			unlock_s2_r <= unlock_s1_r;
		end
	end

	// Signed timing terms
	assign tw_us    = {4'h0, timing_r.tx_warmup_duration};
	assign trim2_us = {{5{timing_r.ack_time_trim[5]}}, timing_r.ack_time_trim, 1'b0}; // [R13]
	assign slot_pre = 12'(SFD_OFFSET_US) + tw_us + trim2_us; // [R4]
	assign ack_pre  = 12'(TURNAROUND_US) - tw_us - trim2_us + 12'(SYMBOL_US * ACK_EXTRA_SYMS); // [R12]
	assign ack_needed = ctrl_r.auto_ack_enable && !ctrl_r.accept_all && ack_req_r; // [R11]
	assign wait_done  = wait_us_r[11] || (wait_us_r == 12'h000);
	assign launch_rx  = (ctrl_r.sequence_select == SEL_RX) || ctrl_r.cca_before_tx;

	// Abort sources: software idle write, bracket timeout, qualified unlock
	always_comb begin
		abort_req = 1'b0;
		if (seq_wr_r && ctrl_r.sequence_select == SEL_IDLE && state_r != ST_IDLE && state_r != ST_ABORT)
			abort_req = 1'b1; // [R23]
		if (bracket_timer && ctrl_r.bracket_timeout_enable &&
		    (state_r == ST_PREAMBLE || state_r == ST_SFD || state_r == ST_RX_DATA))
			abort_req = 1'b1; // [R3]
		// Unlock is expected while warming up, so only later states count
		if (unlock_s2_r && !ctrl_r.lock_loss_abort_disable &&
		    (state_r == ST_PREAMBLE || state_r == ST_SFD || state_r == ST_RX_DATA ||
		     state_r == ST_CCA || state_r == ST_CCA_GAP || state_r == ST_ACK_WAIT || state_r == ST_TX_FRAME))
			abort_req = 1'b1; // [R24]
	end

	// Sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r           <= ST_IDLE;
			wait_us_r         <= 12'h000;
			extra_slot_r      <= 1'b0;
			second_cca_r      <= 1'b0;
			tx_ack_mode       <= 1'b0;
			cca_start         <= 1'b0;
			tx_frame_start    <= 1'b0;
			rx_done_irq       <= 1'b0;
			tx_done_irq       <= 1'b0;
			sequence_done_irq <= 1'b0;
		end else begin
			cca_start         <= 1'b0;
			tx_frame_start    <= 1'b0;
			rx_done_irq       <= 1'b0;
			tx_done_irq       <= 1'b0;
			sequence_done_irq <= 1'b0;
			if (tick && !wait_done)
				wait_us_r <= wait_us_r - 12'(STEP_US);
			if (abort_req) begin
				state_r   <= ST_ABORT;
				wait_us_r <= 12'(ABORT_WDOWN_US);
			end else begin
				unique case (state_r)
					ST_IDLE, ST_WAIT_TRIG: begin
						// Codes other than receive and transmit start nothing here
						if ((state_r == ST_IDLE && seq_wr_r && !ctrl_r.timer_trigger_enable) ||
						    (state_r == ST_WAIT_TRIG && start_compare_timer)) begin // [R1]
							if (ctrl_r.sequence_select == SEL_RX || ctrl_r.sequence_select == SEL_TX) begin
								tx_ack_mode <= 1'b0;
								if (launch_rx) begin
									state_r   <= ST_RX_WARMUP;
									wait_us_r <= 12'(RX_WARMUP_US); // [R2]
								end else begin
									state_r   <= ST_TX_WARMUP;
									wait_us_r <= tw_us;
								end
							end
						end else if (state_r == ST_IDLE && seq_wr_r &&
						             (ctrl_r.sequence_select == SEL_RX || ctrl_r.sequence_select == SEL_TX))
							state_r <= ST_WAIT_TRIG; // [R1]
					end
					ST_RX_WARMUP: begin
						if (wait_done) begin
							if (ctrl_r.sequence_select == SEL_RX)
								state_r <= ST_PREAMBLE; // [R4]
							else begin
								state_r      <= ST_CCA; // [R21]
								cca_start    <= 1'b1;
								second_cca_r <= 1'b0;
								wait_us_r    <= 12'(SLOT_US);
							end
						end
					end
					ST_CCA: begin
						if (cca_done) begin
							if (cca_busy)
								state_r <= ST_ABORT; // [R21]
							else if (ctrl_r.slotted && !second_cca_r)
								state_r <= ST_CCA_GAP;
							else if (ctrl_r.slotted) begin
								// Start warmup early so it ends on the slot edge
								state_r   <= ST_CCA_GAP;
								wait_us_r <= wait_us_r - tw_us;
							end else begin
								state_r   <= ST_TX_WARMUP;
								wait_us_r <= tw_us;
							end
						end
					end
					ST_CCA_GAP: begin
						if (wait_done && !second_cca_r) begin
							state_r      <= ST_CCA;
							cca_start    <= 1'b1;
							second_cca_r <= 1'b1;
							wait_us_r    <= 12'(SLOT_US);
						end else if (wait_done) begin
							state_r   <= ST_TX_WARMUP;
							wait_us_r <= tw_us;
						end
					end
					ST_PREAMBLE: begin
						if (preamble_det)
							state_r <= ST_SFD; // [R4]
					end
					ST_SFD: begin
						if (sfd_det)
							state_r <= ST_RX_DATA;
					end
					ST_RX_DATA: begin
						if (frame_end_r && frame_bad_r)
							state_r <= ST_PREAMBLE; // [R9]
						else if (frame_end_r) begin
							rx_done_irq <= 1'b1; // [R10]
							state_r     <= ST_RX_WDOWN;
							wait_us_r   <= 12'(RX_WARMDOWN_US);
						end
					end
					ST_RX_WDOWN: begin
						if (wait_done && ack_needed) begin // [R11]
							state_r      <= ST_ACK_WAIT;
							wait_us_r    <= ack_pre; // [R12]
							extra_slot_r <= (9'(SLOT_US) - slot_cnt_r) < 9'(TURNAROUND_US); // [R14]
						end else if (wait_done) begin
							sequence_done_irq <= 1'b1;
							state_r           <= ST_IDLE;
						end
					end
					ST_ACK_WAIT: begin
						if (ctrl_r.slotted) begin
							if (slot_roll_r && extra_slot_r)
								extra_slot_r <= 1'b0; // [R14]
							else if (slot_roll_r) begin
								state_r     <= ST_TX_WARMUP; // [R15]
								wait_us_r   <= tw_us;
								tx_ack_mode <= 1'b1;
							end
						end else if (wait_done) begin
							state_r     <= ST_TX_WARMUP; // [R15]
							wait_us_r   <= tw_us;
							tx_ack_mode <= 1'b1;
						end
					end
					ST_TX_WARMUP: begin
						if (wait_done) begin
							state_r        <= ST_TX_FRAME;
							tx_frame_start <= 1'b1;
						end
					end
					ST_TX_FRAME: begin
						if (tx_frame_done) begin
							tx_done_irq <= 1'b1; // [R20]
							state_r     <= ST_TX_WDOWN;
							wait_us_r   <= 12'(TX_WARMDOWN_US);
						end
					end
					ST_TX_WDOWN, ST_ABORT: begin
						if (wait_done) begin
							sequence_done_irq <= 1'b1; // [R20] [R23]
							state_r           <= ST_IDLE;
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Slot timer in microseconds, two per tick
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			slot_cnt_r  <= 9'h000;
			slot_run_r  <= 1'b0;
			slot_roll_r <= 1'b0;
		end else begin
			slot_roll_r <= 1'b0;
			if (state_r == ST_SFD && sfd_det) begin
				slot_run_r <= 1'b1;
				if (slot_pre >= 12'(SLOT_US))
					slot_cnt_r <= 9'(slot_pre - 12'(SLOT_US)); // [R4]
				else
					slot_cnt_r <= slot_pre[8:0];
			end else if (state_r == ST_IDLE)
				slot_run_r <= 1'b0;
			else if (slot_run_r && tick) begin
				if (slot_cnt_r + 9'(STEP_US) > 9'(SLOT_LAST_US)) begin
					slot_cnt_r  <= slot_cnt_r + 9'(STEP_US) - 9'(SLOT_US); // [R5]
					slot_roll_r <= 1'b1;
				end else
					slot_cnt_r <= slot_cnt_r + 9'(STEP_US);
			end
		end
	end

	assign last_octet = (idx_r == 3'h0) ? (rx_octet == 8'h00) : (left_r == 7'h01);

	// Receive datapath: buffer writes and header parsing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_r       <= 7'h00;
			left_r      <= 7'h00;
			idx_r       <= 3'h0;
			ack_req_r   <= 1'b0;
			frame_ver_r <= 2'h0;
			rx_seq_r    <= 8'h00;
			frame_end_r <= 1'b0;
			frame_bad_r <= 1'b0;
			pbuf_we     <= 1'b0;
			pbuf_addr   <= 7'h00;
			pbuf_wdata  <= 8'h00;
		end else begin
			pbuf_we     <= 1'b0;
			frame_end_r <= 1'b0;
			if (state_r == ST_SFD && sfd_det) begin
				ptr_r <= 7'h00; // [R25]
				idx_r <= 3'h0;
			end else if (state_r == ST_RX_DATA && rx_octet_valid && !frame_end_r) begin
				pbuf_we    <= 1'b1; // [R6]
				pbuf_addr  <= ptr_r;
				pbuf_wdata <= rx_octet;
				ptr_r      <= ptr_r + 7'h01;
				if (idx_r != IDX_DONE)
					idx_r <= idx_r + 3'h1;
				if (idx_r == 3'h0)
					left_r <= rx_octet[7] ? MAX_PAYLOAD : rx_octet[6:0]; // [R7]
				else
					left_r <= left_r - 7'h01;
				if (idx_r == IDX_FCF_LO)
					ack_req_r <= rx_octet[FCF_ACKREQ]; // [R8]
				if (idx_r == IDX_FCF_HI)
					frame_ver_r <= rx_octet[FCF_FV_LO +: 2]; // [R8]
				if (idx_r == IDX_SEQ)
					rx_seq_r <= rx_octet; // [R8]
				if (last_octet) begin
					frame_end_r <= 1'b1;
					frame_bad_r <= filter_fail || !crc_ok; // [R9]
				end
			end
		end
	end

	// Hardware acknowledgement, never read from the packet buffer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ack_frame <= '0;
		else if (state_r == ST_ACK_WAIT) begin // [R16]
			ack_frame.fcf <= {2'h0, frame_ver_r, 2'h0, 3'h0, 1'b0, 1'b0,
			                  ctrl_r.source_match_enable ? src_match_pending : ctrl_r.ack_pending_default,
			                  1'b0, FTYPE_ACK}; // [R17] [R18]
			ack_frame.seq <= rx_seq_r; // [R19]
		end
	end

	// Radio enables lag state by one clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
		end else begin
			rx_enable <= (state_r == ST_RX_WARMUP) || (state_r == ST_PREAMBLE) || (state_r == ST_SFD) ||
			             (state_r == ST_RX_DATA) || (state_r == ST_CCA) || (state_r == ST_CCA_GAP);
			tx_enable <= (state_r == ST_TX_WARMUP) || (state_r == ST_TX_FRAME);
		end
	end

endmodule

// ===== verification/rsa_rx_seq_props.sv
// Port checker for the receive sequencer
module rsa_rx_seq_props
	import rsa_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       rx_octet_valid,
	input wire logic       tx_frame_done,
	input wire logic       rx_enable,
	input wire logic       tx_ack_mode,
	input wire logic       tx_frame_start,
	input wire rsa_ack_t   ack_frame,
	input wire logic       pbuf_we,
	input wire logic [6:0] pbuf_addr,
	input wire logic [7:0] pbuf_wdata,
	input wire logic       rx_done_irq,
	input wire logic       tx_done_irq,
	input wire logic       sequence_done_irq
);
	logic [6:0] last_r;
	logic [6:0] cap_r;
	logic [10:0] txw_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Cycles since tx done; a 10 us warmdown plus tick phase stays well below the limit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			txw_r <= 11'h000;
		else if (tx_done_irq)
			txw_r <= 11'h001;
		else if (sequence_done_irq)
			txw_r <= 11'h000;
		else if (txw_r != 11'h000)
			txw_r <= txw_r + 11'h001;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			last_r <= 7'h00;
			cap_r  <= 7'h00;
		end else if (pbuf_we) begin
			last_r <= pbuf_addr;
			if (pbuf_addr == 7'h00)
				cap_r <= pbuf_wdata[7] ? MAX_PAYLOAD : pbuf_wdata[6:0];
		end
	end
	chk_irq_single: assert property (rx_done_irq |=> !rx_done_irq)
		else $error("rx done wider than one cycle");
	chk_we_cause: assert property (pbuf_we |-> $past(rx_octet_valid))
		else $error("buffer write without octet");
	chk_addr_step: assert property (pbuf_we && pbuf_addr != 7'h00 |-> pbuf_addr == last_r + 7'h01)
		else $error("buffer address did not advance by one");
	chk_addr_cap: assert property (pbuf_we && pbuf_addr != 7'h00 |-> pbuf_addr <= cap_r)
		else $error("more octets stored than the capped length");
	chk_rx_wdown: assert property (rx_done_irq |-> ##[1:2] !rx_enable)
		else $error("receiver not warmed down after rx done");
	chk_ack_fcf: assert property (tx_frame_start && tx_ack_mode |-> ack_frame.fcf[3:0] == {1'b0, FTYPE_ACK}
		&& ack_frame.fcf[11:5] == 7'h00 && ack_frame.fcf[15:14] == 2'h0)
		else $error("ack frame control bits wrong");
	chk_ack_nobuf: assert property (tx_frame_start && tx_ack_mode |-> (!pbuf_we) [*8])
		else $error("packet buffer touched during ack");
	chk_seq_after_tx: assert property (txw_r < 11'h514)
		else $error("no sequence done after tx done");
	chk_txdone_cause: assert property (tx_done_irq |-> $past(tx_frame_done) || $past(tx_frame_done, 2))
		else $error("tx done without frame end");
endmodule

bind rsa_rx_seq rsa_rx_seq_props u_props (.clk, .rst_b, .rx_octet_valid, .tx_frame_done, .rx_enable, .tx_ack_mode,
	.tx_frame_start, .ack_frame, .pbuf_we, .pbuf_addr, .pbuf_wdata, .rx_done_irq, .tx_done_irq, .sequence_done_irq);

// ===== verification/rsa_radio_model.sv
// Radio channel model: frame start in, demodulator events and modulator completion out
module rsa_radio_model (
	input  wire logic       clk,
	input  wire logic       tx_frame_start,
	output logic            preamble_det,
	output logic            sfd_det,
	output logic            rx_octet_valid,
	output logic      [7:0] rx_octet,
	output logic            filter_fail,
	output logic            crc_ok,
	output logic            tx_frame_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] frame_q[$];
	initial {preamble_det, sfd_det, rx_octet_valid, rx_octet, filter_fail, crc_ok, tx_frame_done} = '0;
	always @(posedge clk) begin
		tx_frame_done <= 1'b0;
		if (tx_frame_start === 1'b1) begin
			repeat (200) @(posedge clk);
			tx_frame_done <= 1'b1;
		end
	end
	// Data inverted between octets so stale values never match
	task automatic send(input logic good);
		@(posedge clk);
		preamble_det <= 1'b1;
		@(posedge clk);
		preamble_det <= 1'b0;
		repeat (20) @(posedge clk);
		sfd_det <= 1'b1;
		@(posedge clk);
		sfd_det <= 1'b0;
		while (frame_q.size() > 0) begin
			repeat (8) @(posedge clk);
			rx_octet       <= frame_q.pop_front();
			rx_octet_valid <= 1'b1;
			crc_ok         <= good;
			@(posedge clk);
			rx_octet_valid <= 1'b0;
			rx_octet       <= ~rx_octet;
		end
	endtask
endmodule

// ===== verification/rsa_rx_seq_tb.sv
// Self-checking bench for the receive sequencer with automatic acknowledgement
module rsa_rx_seq_tb
	import rsa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TW      = 30;
	localparam int TRIM    = -5;
	localparam int ACK_CYC = (RX_WARMDOWN_US + TURNAROUND_US - 2 * TRIM + SYMBOL_US * ACK_EXTRA_SYMS) * 100;
	logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
	logic [1:0]  htrans = 2'h0;
	logic        start_compare_timer = 1'b0, bracket_timer = 1'b0, pll_unlock = 1'b0, src_match_pending = 1'b0;
	logic        preamble_det, sfd_det, rx_octet_valid, filter_fail, crc_ok, tx_frame_done, tx_frame_start;
	logic        rx_enable, tx_enable, tx_ack_mode, pbuf_we, rx_done_irq, tx_done_irq, sequence_done_irq;
	logic [7:0]  rx_octet, pbuf_wdata, seq_v;
	logic [6:0]  pbuf_addr;
	rsa_ack_t    ack_frame, ack_seen;
	logic [7:0]  exp_q[$], wd_q[$];
	int          wa_q[$];
	int          evt[4] = '{default: 0};
	int          cyc = 0, t_rx = 0, t_ack = 0, fail_count = 0, total_checks = 0, n0, i;
	logic [31:0] seed;
	assign hready = hreadyout;
	always #5 clk = ~clk;
	rsa_rx_seq u_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize({1'b0, htrans}), .hwdata, .hready, .hrdata,
		.hreadyout, .hresp(), .start_compare_timer, .bracket_timer, .pll_unlock, .preamble_det, .sfd_det,
		.rx_octet_valid, .rx_octet, .filter_fail, .crc_ok, .src_match_pending, .cca_done(1'b0), .cca_busy(1'b0),
		.tx_frame_done, .rx_enable, .tx_enable, .cca_start(), .tx_frame_start, .tx_ack_mode, .ack_frame, .pbuf_we,
		.pbuf_addr, .pbuf_wdata, .rx_done_irq, .tx_done_irq, .sequence_done_irq);
	rsa_radio_model u_radio (.clk, .tx_frame_start, .preamble_det, .sfd_det, .rx_octet_valid, .rx_octet,
		.filter_fail, .crc_ok, .tx_frame_done);
	task automatic final_report;
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rx_done_irq === 1'b1) begin
			evt[0] <= evt[0] + 1;
			t_rx   <= cyc;
		end
		if (tx_done_irq === 1'b1)
			evt[1] <= evt[1] + 1;
		if (sequence_done_irq === 1'b1)
			evt[2] <= evt[2] + 1;
		if (tx_frame_start === 1'b1 && tx_ack_mode === 1'b1) begin
			evt[3]   <= evt[3] + 1;
			t_ack    <= cyc;
			ack_seen <= ack_frame;
		end
		if (pbuf_we === 1'b1) begin
			wa_q.push_back(pbuf_addr);
			wd_q.push_back(pbuf_wdata);
		end
		if (cyc == 99000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic [11:0] a, input logic wr, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rdv = hrdata;
		@(posedge clk);
	endtask
	task automatic wait_evt(input int k, input int n);
		int c;
		for (c = 0; c < 30000 && evt[k] < n; c++)
			@(posedge clk);
		check("event count", evt[k], n);
	endtask
	task automatic load(input logic [7:0] len, input logic [7:0] lo, input logic [7:0] hi, input int extra);
		exp_q = {len, lo, hi, seq_v};
		repeat (extra)
			exp_q.push_back(8'($random(seed)));
		u_radio.frame_q = exp_q;
		wa_q = {};
		wd_q = {};
	endtask
	task automatic buf_chk(input int n);
		int k;
		check("buffer writes", wa_q.size(), n);
		for (k = 0; k < n && k < wa_q.size(); k++) begin
			check("buffer address", wa_q[k], k);
			check("buffer data", wd_q[k], exp_q[k]);
		end
	endtask
	task automatic state_is(input string name, input logic [3:0] s);
		xfer(ADDR_STATUS, 1'b0, 32'h0);
		check(name, rdv[3:0], s);
	endtask
	initial begin
		seed = 32'h8698;
		seq_v = 8'($random(seed));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		src_match_pending <= 1'($random(seed));
		@(posedge clk);
		for (i = 0; i < 5; i++) begin
			xfer(12'(i * 4), 1'b0, 32'h0);
			check("reset word", rdv, 32'h0);
		end
		xfer(ADDR_CTRL, 1'b1, 32'h009);
		repeat (50) @(posedge clk);
		state_is("wait trig", ST_WAIT_TRIG);
		start_compare_timer <= 1'b1;
		@(posedge clk);
		start_compare_timer <= 1'b0;
		state_is("triggered", ST_RX_WARMUP);
		xfer(ADDR_CTRL, 1'b1, {29'h0, SEL_TX});
		state_is("ignored", ST_RX_WARMUP);
		xfer(ADDR_CTRL, 1'b1, 32'h0);
		wait_evt(2, 1);
		state_is("aborted", ST_IDLE);
		for (i = 0; i < 2; i++) begin
			xfer(ADDR_CTRL, 1'b1, i ? 32'h001 : 32'h011);
			repeat (14500) @(posedge clk);
			if (i == 0)
				bracket_timer <= 1'b1;
			else
				pll_unlock <= 1'b1;
			@(posedge clk);
			bracket_timer <= 1'b0;
			wait_evt(2, 2 + i);
			pll_unlock <= 1'b0;
			state_is("abort idle", ST_IDLE);
			xfer(ADDR_CTRL, 1'b1, 32'h0);
		end
		xfer(ADDR_TIMING, 1'b1, {18'h0, 6'(TRIM), 8'(TW)});
		xfer(ADDR_CTRL, 1'b1, 32'h121);
		n0 = evt[2];
		repeat (14100) @(posedge clk);
		state_is("warming", ST_RX_WARMUP);
		repeat (350) @(posedge clk);
		state_is("searching", ST_PREAMBLE);
		load(8'hFF, 8'h21, 8'h20, 126);
		u_radio.send(1'b0);
		repeat (5) @(posedge clk);
		buf_chk(128);
		state_is("bad frame dropped", ST_PREAMBLE);
		check("no rx done", evt[0], 0);
		load(8'h05, 8'h21, 8'h20, 2);
		u_radio.send(1'b1);
		wait_evt(0, 1);
		buf_chk(6);
		wait_evt(3, 1);
		check("ack delay", (t_ack - t_rx > ACK_CYC - 600) && (t_ack - t_rx < ACK_CYC + 600), 1);
		check("ack frame", ack_seen, {4'h2, 7'h00, src_match_pending, 4'h2, seq_v});
		wait_evt(1, 1);
		wait_evt(2, n0 + 1);
		xfer(ADDR_RXINFO, 1'b0, 32'h0);
		check("received fields", rdv[10:0], {3'b110, seq_v});
		state_is("idle after ack", ST_IDLE);
		xfer(ADDR_CTRL, 1'b1, 32'h0);
		xfer(ADDR_CTRL, 1'b1, 32'h221);
		n0 = evt[2];
		repeat (14500) @(posedge clk);
		load(8'h05, 8'h01, 8'h10, 2);
		u_radio.send(1'b1);
		wait_evt(0, 2);
		wait_evt(2, n0 + 1);
		check("no ack sent", evt[3], 1);
		buf_chk(6);
		xfer(ADDR_CTRL, 1'b1, 32'h0);
		final_report();
	end
endmodule
